//--- sdw_top.sv
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "sdw_map.svh"
module sdw_top
	import sdw_pkg::*;
#(
	parameter int SLOW_DIV = `SDW_SLOW_DIV,
	parameter bit CRYSTAL_CLOCK = 1'b0
)
(
	input wire logic SYS_CLK,
	input wire logic RESETN,
	input wire logic [1:0] DOG_CFG_MODE,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic KICK_INSTRUCTION,
	input wire logic SLEEP_REQ,
	input wire logic IRQ_PENDING,
	input wire logic WAKE_EVENT,
	input wire logic OSC_FAIL,
	input wire logic OSC_START_TIMER,
	input wire logic [3:0] INT_OSC_DIVIDER,
	output logic ASLEEP,
	output logic DOG_RESET,
	output logic DOG_WAKE,
	output logic EXPIRY_FLAG_N,
	output logic SLEEP_FLAG_N
);
	import sdw_pkg::*;
	sdw_if link();
	sdw_mode_type mode;
	sdw_state_type state_reg, state_next;
	logic [4:0] period_reg, period_next;
	logic enable_reg, enable_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [$clog2(SLOW_DIV+1)-1:0] div_reg, div_next;
	logic to_n_reg, to_n_next, pd_n_reg, pd_n_next;
	logic rst_reg, rst_next, wake_reg, wake_next;
	logic [1:0] ost_sync, fail_sync;
	logic active, sleep_ok, tick, enter_sleep, exit_sleep;
	logic other_clear, hit;
	// The oscillator pins OSC_FAIL and OSC_START_TIMER pass two flops; first stage is read by the second only
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			ost_sync <= 2'b00;
			fail_sync <= 2'b00;
		end
		else
		begin
			ost_sync <= {ost_sync[0], OSC_START_TIMER};
			fail_sync <= {fail_sync[0], OSC_FAIL};
		end
	end
	assign mode = sdw_mode_type'(DOG_CFG_MODE);
	assign sleep_ok = !IRQ_PENDING;
	assign enter_sleep = (state_reg == SDW_AWAKE) && SLEEP_REQ && sleep_ok;
	// Expiry is weighed against every other clear, which keeps the path from the
	// count through exit_sleep back into the clear free of a loop
	assign other_clear = KICK_INSTRUCTION || !active || fail_sync[1] || ost_sync[1]
		|| enter_sleep || (state_reg == SDW_ASLEEP && WAKE_EVENT);
	assign hit = link.expire && !other_clear;
	assign exit_sleep = (state_reg == SDW_ASLEEP) && (WAKE_EVENT || hit);
	always_comb
	begin
		case (mode)
			SDW_ALWAYS: active = 1'b1;
			SDW_NOSLEEP: active = (state_reg == SDW_AWAKE);
			SDW_SWCTL: active = enable_reg && (state_reg != SDW_HOLD);
			SDW_OFF: active = 1'b0;
			default: active = 1'b0;
		endcase
		if (state_reg == SDW_HOLD)
			active = 1'b0;
	end
	// Slow oscillator time base from the system clock; the divider ignores the
	// internal oscillator divider setting so the count never jumps
	always_comb
	begin
		div_next = div_reg + 1'b1;
		tick = 1'b0;
		if (div_reg == $bits(div_reg)'(SLOW_DIV - 1))
		begin
			div_next = '0;
			tick = 1'b1;
		end
		if (link.clear)
			div_next = '0;
	end
	assign link.tick = tick && active;
	assign link.period = period_reg;
	// Kick arrives on this clock, so a single pulse clears exactly once
	assign link.clear = other_clear || hit;
	always_comb
	begin
		state_next = state_reg;
		to_n_next = to_n_reg;
		pd_n_next = pd_n_reg;
		rst_next = 1'b0;
		wake_next = 1'b0;
		case (state_reg)
			SDW_AWAKE:
			begin
				if (hit)
				begin
					rst_next = 1'b1;
					to_n_next = 1'b0;
				end
				else if (enter_sleep)
				begin
					state_next = SDW_ASLEEP;
					pd_n_next = 1'b0;
				end
				else if (KICK_INSTRUCTION)
				begin
					to_n_next = 1'b1;
					pd_n_next = 1'b1;
				end
			end
			SDW_ASLEEP:
			begin
				if (exit_sleep)
				begin
					state_next = CRYSTAL_CLOCK ? SDW_HOLD : SDW_AWAKE;
					if (hit)
					begin
						wake_next = 1'b1;
						to_n_next = 1'b0;
					end
				end
			end
			SDW_HOLD:
			begin
				if (!ost_sync[1])
					state_next = SDW_AWAKE;
			end
			default: state_next = SDW_AWAKE;
		endcase
	end
	always_comb
	begin
		period_next = period_reg;
		enable_next = enable_reg;
		rdata_next = 8'h00;
		if (WR && ADDR == `SDW_ADDR_CONTROL)
		begin
			period_next = WDATA[`SDW_PS_MSB:`SDW_PS_LSB];
			enable_next = WDATA[`SDW_EN_BIT];
		end
		if (RD)
		begin
			case (ADDR)
				`SDW_ADDR_CONTROL: rdata_next = {2'b00, period_reg, enable_reg};
				`SDW_ADDR_STATUS: rdata_next = {5'h00, state_reg == SDW_ASLEEP, to_n_reg, pd_n_reg};
				default: rdata_next = 8'h00;
			endcase
		end
	end
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			state_reg <= SDW_AWAKE;
			period_reg <= `SDW_PS_RESET;
			enable_reg <= 1'b0;
			rdata_reg <= 8'h00;
			div_reg <= '0;
			to_n_reg <= 1'b1;
			pd_n_reg <= 1'b1;
			rst_reg <= 1'b0;
			wake_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			period_reg <= period_next;
			enable_reg <= enable_next;
			rdata_reg <= rdata_next;
			div_reg <= div_next;
			to_n_reg <= to_n_next;
			pd_n_reg <= pd_n_next;
			rst_reg <= rst_next;
			wake_reg <= wake_next;
		end
	end
	sdw_counter u_counter (
		.SYS_CLK(SYS_CLK),
		.RESETN(RESETN),
		.bus(link)
	);
	assign RDATA = rdata_reg;
	assign DOG_RESET = rst_reg;
	assign DOG_WAKE = wake_reg;
	assign EXPIRY_FLAG_N = to_n_reg;
	assign SLEEP_FLAG_N = pd_n_reg;
	assign ASLEEP = (state_reg == SDW_ASLEEP);
	property p_expire_reset;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(hit && state_reg == SDW_AWAKE) |=> DOG_RESET && !EXPIRY_FLAG_N;
	endproperty
	a_expire_reset: assert property (p_expire_reset) else $error("no reset on expiry");
	property p_sleep_wake;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(hit && state_reg == SDW_ASLEEP) |=> DOG_WAKE && !DOG_RESET;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep expiry not a wake");
	property p_off_mode;
		@(posedge SYS_CLK) disable iff (!RESETN) (mode == SDW_OFF) |-> !link.tick;
	endproperty
	a_off_mode: assert property (p_off_mode) else $error("counting while off");
	property p_nosleep;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(mode == SDW_NOSLEEP && state_reg == SDW_ASLEEP) |-> link.clear;
	endproperty
	a_nosleep: assert property (p_nosleep) else $error("running in sleep");
	property p_swctl;
		@(posedge SYS_CLK) disable iff (!RESETN) (mode == SDW_SWCTL && !enable_reg) |-> link.clear;
	endproperty
	a_swctl: assert property (p_swctl) else $error("soft disable ignored");
	property p_always;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(mode == SDW_ALWAYS && state_reg != SDW_HOLD) |-> active;
	endproperty
	a_always: assert property (p_always) else $error("always mode inactive");
	property p_irq_sleep;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(state_reg == SDW_AWAKE && SLEEP_REQ && IRQ_PENDING) |=> state_reg == SDW_AWAKE;
	endproperty
	a_irq_sleep: assert property (p_irq_sleep) else $error("sleep taken with irq");
	property p_ctrl_read;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(RD && ADDR == `SDW_ADDR_CONTROL) |=> RDATA[7:6] == 2'b00;
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("upper bits not zero");
	property p_kick_flags;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(state_reg == SDW_AWAKE && KICK_INSTRUCTION && !enter_sleep)
		|=> EXPIRY_FLAG_N && SLEEP_FLAG_N;
	endproperty
	a_kick_flags: assert property (p_kick_flags) else $error("kick left a flag low");
	sequence s_sleep_taken;
		state_reg == SDW_AWAKE && SLEEP_REQ && !IRQ_PENDING;
	endsequence
	property p_sleep_entry;
		@(posedge SYS_CLK) disable iff (!RESETN)
		s_sleep_taken |-> link.clear ##1 (ASLEEP && !SLEEP_FLAG_N);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("bad sleep entry");
	property p_wake_clear;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(state_reg == SDW_ASLEEP && WAKE_EVENT) |-> link.clear ##1 !ASLEEP;
	endproperty
	a_wake_clear: assert property (p_wake_clear) else $error("wake did not clear");
	property p_swctl_run;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(mode == SDW_SWCTL && enable_reg && state_reg != SDW_HOLD) |-> active;
	endproperty
	a_swctl_run: assert property (p_swctl_run) else $error("soft enable ignored");
	// A pin level reaches the clear two edges later, through the synchroniser
	sequence s_two_late(sig);
		$past(RESETN, 2) && $past(RESETN) && $past(sig, 2);
	endsequence
	property p_fail_clear;
		@(posedge SYS_CLK) disable iff (!RESETN)
		s_two_late(OSC_FAIL) |-> link.clear;
	endproperty
	a_fail_clear: assert property (p_fail_clear) else $error("osc fail no clear");
	property p_start_clear;
		@(posedge SYS_CLK) disable iff (!RESETN)
		s_two_late(OSC_START_TIMER) |-> link.clear;
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("start timer no clear");
	sequence s_sleep_expiry;
		hit && state_reg == SDW_ASLEEP;
	endsequence
	// One cycle of wake pulse, so the core sees a single event
	property p_wake_pulse;
		@(posedge SYS_CLK) disable iff (!RESETN)
		s_sleep_expiry |=> (DOG_WAKE && !EXPIRY_FLAG_N && !SLEEP_FLAG_N) ##1 !DOG_WAKE;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("bad wake pulse");
	property p_reset_pulse;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(hit && state_reg == SDW_AWAKE) |=> DOG_RESET ##1 !DOG_RESET;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("bad reset pulse");
	property p_read_idle;
		@(posedge SYS_CLK) disable iff (!RESETN)
		!RD |=> RDATA == 8'h00;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("data without read");
	property p_irq_keep;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(state_reg == SDW_AWAKE && SLEEP_REQ && IRQ_PENDING && !KICK_INSTRUCTION)
		|=> $stable(SLEEP_FLAG_N);
	endproperty
	a_irq_keep: assert property (p_irq_keep) else $error("no-op sleep moved flag");
	property p_ctrl_write;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(WR && ADDR == `SDW_ADDR_CONTROL)
		|=> {period_reg, enable_reg} == $past(WDATA[`SDW_PS_MSB:`SDW_EN_BIT]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");
endmodule

//--- sdw_map.svh
`ifndef SDW_MAP_SVH
`define SDW_MAP_SVH
`define SDW_ADDR_CONTROL 4'h0
`define SDW_ADDR_STATUS 4'h1
`define SDW_EN_BIT 0
`define SDW_PS_LSB 1
`define SDW_PS_MSB 5
`define SDW_PS_RESET 5'h0B
`define SDW_PS_MAX 5'h12
`define SDW_BASE_LOG2 5
`define SDW_CLK_HZ 25000000
`define SDW_SLOW_HZ 31000
`define SDW_SLOW_DIV (`SDW_CLK_HZ / `SDW_SLOW_HZ)
`endif

//--- sdw_pkg.sv
package sdw_pkg;
	typedef enum logic [1:0] {SDW_OFF, SDW_SWCTL, SDW_NOSLEEP, SDW_ALWAYS} sdw_mode_type;
	typedef enum {SDW_AWAKE, SDW_ASLEEP, SDW_HOLD} sdw_state_type;
endpackage

//--- sdw_if.sv
`timescale 1ns/1ps
interface sdw_if;
	logic tick;
	logic clear;
	logic [4:0] period;
	logic expire;
	modport ctl (output tick, output clear, output period, input expire);
	modport cnt (input tick, input clear, input period, output expire);
endinterface

//--- sdw_counter.sv
`timescale 1ns/1ps
`include "sdw_map.svh"
module sdw_counter
	import sdw_pkg::*;
#(
	parameter int WIDTH = 28
)
(
	input wire logic SYS_CLK,
	input wire logic RESETN,
	sdw_if.cnt bus
);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic [WIDTH-1:0] limit;
	logic [4:0] eff;
	always_comb
	begin
		// Reserved codes fall back to the shortest interval
		eff = (bus.period > `SDW_PS_MAX) ? 5'h00 : bus.period;
		limit = WIDTH'(1) << (eff + 5'(`SDW_BASE_LOG2));
		count_next = count_reg;
		if (bus.clear)
			count_next = '0;
		else if (bus.tick)
			count_next = count_reg + WIDTH'(1);
	end
	always_ff @(posedge SYS_CLK or negedge RESETN)
	begin
		if (!RESETN)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end
	// Raw expiry; the controller weighs it against its other clears
	assign bus.expire = (count_reg >= limit - WIDTH'(1)) && bus.tick;
	property p_clear_zero;
		@(posedge SYS_CLK) disable iff (!RESETN) bus.clear |=> count_reg == '0;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("count not cleared");
	property p_hold_no_tick;
		@(posedge SYS_CLK) disable iff (!RESETN)
		(!bus.tick && !bus.clear) |=> $stable(count_reg);
	endproperty
	a_hold_no_tick: assert property (p_hold_no_tick) else $error("count moved without tick");
endmodule

//--- sdw_core_model.sv
`timescale 1ns/1ps
module sdw_core_model
(
	input wire logic clk,
	input wire logic kick_on,
	output logic kick,
	output logic [3:0] divider
)
;
	int n = 0;
	logic kick_reg = 1'b0;
	logic [3:0] divider_reg = 4'h0;
	assign kick = kick_reg;
	assign divider = divider_reg;
	// Divider walks every cycle so any hidden coupling to the count shows
	always @(posedge clk)
	begin
		divider_reg <= divider_reg + 4'h1;
		n = kick_on ? n + 1 : 0;
		kick_reg <= (n == 40);
		if (n == 40)
			n = 0;
	end
endmodule

//--- sleep_aware_watchdog_timer_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) \
	begin comparisons++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected at %0t: got %h want %h", $time, g, e); end end
module sleep_aware_watchdog_timer_tb;
	import sdw_pkg::*;
	localparam int D = 2;
	logic SYS_CLK = 0, RESETN = 0, WR = 0, RD = 0, SLEEP_REQ = 0, IRQ_PENDING = 0;
	logic WAKE_EVENT = 0, OSC_FAIL = 0, OSC_START_TIMER = 0, kick_on = 0;
	logic [1:0] DOG_CFG_MODE = 2'h0;
	logic [3:0] ADDR = 4'h0, INT_OSC_DIVIDER;
	logic [7:0] WDATA = 8'h00, RDATA, d;
	logic KICK_INSTRUCTION, ASLEEP, DOG_RESET, DOG_WAKE, EXPIRY_FLAG_N, SLEEP_FLAG_N;
	int fail_count = 0, comparisons = 0, cyc = 0, n, c;
	always #20 SYS_CLK = ~SYS_CLK;
	sdw_top #(.SLOW_DIV(D)) dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
		.DOG_CFG_MODE(DOG_CFG_MODE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .KICK_INSTRUCTION(KICK_INSTRUCTION), .SLEEP_REQ(SLEEP_REQ),
		.IRQ_PENDING(IRQ_PENDING), .WAKE_EVENT(WAKE_EVENT), .OSC_FAIL(OSC_FAIL),
		.OSC_START_TIMER(OSC_START_TIMER), .INT_OSC_DIVIDER(INT_OSC_DIVIDER),
		.ASLEEP(ASLEEP), .DOG_RESET(DOG_RESET), .DOG_WAKE(DOG_WAKE),
		.EXPIRY_FLAG_N(EXPIRY_FLAG_N), .SLEEP_FLAG_N(SLEEP_FLAG_N));
	sdw_core_model core (.clk(SYS_CLK), .kick_on(kick_on), .kick(KICK_INSTRUCTION),
		.divider(INT_OSC_DIVIDER));
	// Reserved codes fall back to the shortest ratio
	function automatic int exp_cyc(input int code);
		return (1 << ((code > 18) ? 5 : code + 5)) * D;
	endfunction
	function automatic logic near(input int got, input int code);
		return got > exp_cyc(code) - 3 * D - 8 && got < exp_cyc(code) + 3 * D + 8;
	endfunction
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge SYS_CLK);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge SYS_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		#1 v = RDATA;
	endtask
	task automatic pulse(input bit w);
		@(posedge SYS_CLK);
		if (w)
			WAKE_EVENT <= 1'b1;
		else
			SLEEP_REQ <= 1'b1;
		@(posedge SYS_CLK);
		WAKE_EVENT <= 1'b0;
		SLEEP_REQ <= 1'b0;
		@(posedge SYS_CLK);
		#1;
	endtask
	// Counts cycles to the chosen pulse; returns lim when none came
	task automatic wait_ev(input bit w, input int lim, output int k);
		k = 0;
		while (k < lim && (w ? DOG_WAKE : DOG_RESET) !== 1'b1)
		begin
			@(posedge SYS_CLK);
			#1 k++;
		end
	endtask
	task automatic rst(input logic [1:0] m);
		@(posedge SYS_CLK);
		RESETN <= 1'b0;
		DOG_CFG_MODE <= m;
		repeat (6) @(posedge SYS_CLK);
		RESETN <= 1'b1;
	endtask
	task automatic run(input logic [1:0] m, input int code, input logic en);
		rst(m);
		wr(4'h0, {2'b00, code[4:0], en});
	endtask
	task automatic stop_test();
		$display("fail_count %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge SYS_CLK)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			stop_test();
		end
	end
	initial
	begin
		void'($urandom(39543));
		rst(2'h0);
		rd(4'h0, d);
		`CHK(d, 8'h16)
		rd(4'h1, d);
		`CHK(d, 8'h03)
		c = $urandom;
		wr(4'h0, c[7:0]);
		rd(4'h0, d);
		`CHK(d, {2'b00, c[5:0]})
		rd(4'h9, d);
		`CHK(d, 8'h00)
		for (int i = 0; i < 4; i++)
		begin
			c = (i < 3) ? i : 19 + $urandom % 13;
			run(2'(3 - i % 3), c, i == 2);
			wait_ev(1'b0, 3000, n);
			`CHK(near(n, c), 1'b1)
		end
		run(2'h0, 0, 1'b1);
		wait_ev(1'b0, 300, n);
		`CHK(n, 300)
		run(2'h1, 0, 1'b0);
		wait_ev(1'b0, 300, n);
		`CHK(n, 300)
		kick_on <= 1'b1;
		run(2'h1, 0, 1'b1);
		wait_ev(1'b0, 400, n);
		`CHK(n, 400)
		kick_on <= 1'b0;
		wait_ev(1'b0, 300, n);
		`CHK(n < 100, 1'b1)
		run(2'h3, 0, 1'b0);
		OSC_FAIL <= 1'b1;
		wait_ev(1'b0, 300, n);
		`CHK(n, 300)
		OSC_FAIL <= 1'b0;
		OSC_START_TIMER <= 1'b1;
		wait_ev(1'b0, 300, n);
		`CHK(n, 300)
		OSC_START_TIMER <= 1'b0;
		IRQ_PENDING <= 1'b1;
		pulse(1'b0);
		`CHK({ASLEEP, SLEEP_FLAG_N}, 2'b01)
		IRQ_PENDING <= 1'b0;
		pulse(1'b0);
		`CHK({ASLEEP, SLEEP_FLAG_N}, 2'b10)
		wait_ev(1'b1, 300, n);
		`CHK(near(n + 2, 0), 1'b1)
		@(posedge SYS_CLK);
		#1;
		`CHK({ASLEEP, EXPIRY_FLAG_N, SLEEP_FLAG_N, DOG_RESET}, 4'h0)
		run(2'h2, 0, 1'b0);
		pulse(1'b0);
		wait_ev(1'b1, 300, n);
		`CHK({ASLEEP, n == 300}, 2'b11)
		pulse(1'b1);
		`CHK(ASLEEP, 1'b0)
		wait_ev(1'b0, 300, n);
		`CHK(near(n + 2, 0), 1'b1)
		stop_test();
	end
endmodule
